// ---- bench/ssc_command_client_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssc_command_client_bench
  import ssc_pkg::*;
;
  localparam logic [7:0] AD = 8'h49;
  logic clk = 1'b0;
  logic rstn;
  logic slo;
  ssc_rx_t rx;
  logic tx_ready;
  ssc_tx_t tx;
  logic [7:0] dev_addr;
  logic [127:0] dib;
  ssc_sense_t sense;
  logic ext_en;
  logic soft_rst;
  int fail_count = 0;
  int total_checks = 0;
  int pulse_count = 0;

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  // Counts device reset pulses on the status output.
  always @(posedge clk) begin
    if (soft_rst === 1'b1) begin
      pulse_count++;
    end
  end

  // Device and the host model.
  ssc_command_client uut (.i_clk(clk), .i_rstn(rstn), .i_rx(rx), .i_tx_ready(tx_ready), .o_tx(tx),
    .i_dev_addr(dev_addr), .i_dib(dib), .i_sense(sense), .o_ext_enabled(ext_en), .o_soft_reset(soft_rst));
  ssc_host host (.i_clk(clk), .i_tx(tx), .o_rx(rx), .o_tx_ready(tx_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Good frame: check byte, read data low byte first, closing check byte.
  task automatic run(input logic [7:0] w[$], input logic [7:0] rd[$]);
    int n;
    host.frame(w, slo);
    n = rd.size();
    check(host.resp.size(), n + 1 + (n > 0));
    if (host.resp.size() == n + 1 + (n > 0)) begin
      check({host.flg[0], host.resp[0]}, {2'b10, host.crc(w)});
      foreach (rd[i]) check({host.flg[i + 1], host.resp[i + 1]}, {2'b00, rd[i]});
      if (n > 0) check({host.flg[n + 1], host.resp[n + 1]}, {2'b10, host.crc(rd)});
    end
  endtask

  // Rejected frame: one inverted check byte and nothing else.
  task automatic rej(input logic [7:0] w[$]);
    host.frame(w, 1'b0);
    check(host.resp.size(), 1);
    if (host.resp.size() == 1) check({host.flg[0], host.resp[0]}, {2'b11, ~host.crc(w)});
  endtask

  task automatic t_ping();
    run('{AD, 8'h00, 8'h00}, '{});
    host.frame('{AD ^ 8'h01, 8'h00, 8'h00}, 1'b0);
    check(host.resp.size(), 0);
    $display("ping test done");
  endtask

  task automatic t_temps();
    @(posedge clk);
    sense.int_temp <= 16'h1A48;
    sense.ext_temp <= 16'hF3C0;
    run('{AD, 8'h01, 8'h02, 8'h00}, '{8'h48, 8'h1A});
    run('{AD, 8'h01, 8'h02, 8'h01}, '{8'hC0, 8'hF3});
    run('{AD, 8'h01, 8'h04, 8'h00}, '{8'h48, 8'h1A, 8'hC0, 8'hF3});
    @(posedge clk) sense.diode_open <= 1'b1;
    run('{AD, 8'h01, 8'h02, 8'h01}, '{8'h02, 8'h81});
    @(posedge clk) sense.diode_open <= 1'b0;
    sense.diode_short <= 1'b1;
    run('{AD, 8'h01, 8'h02, 8'h01}, '{8'h03, 8'h81});
    $display("temperature test done");
  endtask

  task automatic t_volts();
    logic [15:0] w;
    logic [7:0] all[$];
    @(posedge clk) sense.volt_raw <= {12'hFFF, 12'h140, 12'h1A6, 12'h280, 12'hBF1};
    @(posedge clk);
    for (int c = 0; c < 5; c++) begin
      w = {1'b0, sense.volt_raw[c], 3'b000};
      all.push_back(w[7:0]);
      all.push_back(w[15:8]);
      run('{AD, 8'h01, 8'h02, 8'h10 + 8'(c)}, '{w[7:0], w[15:8]});
    end
    slo = 1'b1;
    run('{AD, 8'h01, 8'h0A, 8'h10}, all);
    slo = 1'b0;
    $display("voltage test done");
  endtask

  task automatic t_dib();
    logic [7:0] q[$];
    for (int n = 8; n <= 16; n += 8) begin
      q.delete();
      for (int i = 0; i < n; i++) q.push_back(dib[8 * i +: 8]);
      run('{AD, 8'h01, 8'(n), 8'hF7}, q);
    end
    rej('{AD, 8'h01, 8'h04, 8'hF7});
    $display("identifier test done");
  endtask

  task automatic t_abort();
    logic [7:0] codes[$] = '{8'h02, 8'h0F, 8'h15, 8'hDF, 8'hE4, 8'hE8, 8'hEF, 8'hF5, 8'hF8, 8'hFF};
    foreach (codes[i]) rej('{AD, 8'h01, 8'h02, codes[i]});
    rej('{AD, 8'h02, 8'h02, 8'h00, 8'h00});
    rej('{AD, 8'h01, 8'h03, 8'h10});
    // Without a stop, a write length fault frees the client and a read length fault does not.
    host.frame('{AD, 8'h02, 8'h02, 8'h00, 8'h00}, 1'b0, 1'b1);
    check(host.resp.size(), 1);
    run('{AD, 8'h00, 8'h00}, '{});
    host.frame('{AD, 8'h01, 8'h03, 8'h10}, 1'b0, 1'b1);
    check(host.resp.size(), 1);
    host.frame('{AD, 8'h01, 8'h02, 8'h00}, 1'b0);
    check(host.resp.size(), 0);
    $display("abort test done");
  endtask

  task automatic t_vendor();
    rej('{AD, 8'h03, 8'h00, 8'hE0, 8'h1F, 8'h77});
    run('{AD, 8'h01, 8'h00, 8'hE2}, '{});
    check(ext_en, 1);
    run('{AD, 8'h04, 8'h00, 8'hE0, 8'h20, 8'h25, 8'h28}, '{});
    run('{AD, 8'h02, 8'h03, 8'hE1, 8'h1F}, '{8'h00, 8'h25, 8'h28});
    run('{AD, 8'h01, 8'h00, 8'hE3}, '{});
    check(ext_en, 0);
    $display("vendor test done");
  endtask

  task automatic t_reset();
    run('{AD, 8'h01, 8'h00, 8'hE2}, '{});
    run('{AD, 8'h03, 8'h00, 8'hE0, 8'h40, 8'h5A}, '{});
    run('{AD, 8'h01, 8'h00, 8'hF6}, '{});
    check(pulse_count, 1);
    check(ext_en, 0);
    run('{AD, 8'h01, 8'h00, 8'hE2}, '{});
    run('{AD, 8'h02, 8'h01, 8'hE1, 8'h40}, '{8'h00});
    $display("reset test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reset for two cycles, then the scenarios in turn.
  initial begin
    rstn = 1'b0;
    slo = 1'b0;
    dev_addr = AD;
    sense = '0;
    for (int i = 0; i < 16; i++) dib[8 * i +: 8] = 8'hA0 + 8'(i);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_ping();
    t_temps();
    t_volts();
    t_dib();
    t_abort();
    t_vendor();
    t_reset();
    end_of_test();
  end

  // Watchdog against a hung link.
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule // ssc_command_client_bench
`default_nettype wire

// ---- bench/ssc_command_client_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssc_command_client_chk
  import ssc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Byte link.
  input wire ssc_rx_t i_rx,
  input wire logic i_tx_ready,
  input wire ssc_tx_t o_tx,
  // Static inputs and results.
  input wire logic [7:0] i_dev_addr,
  input wire logic [127:0] i_dib,
  input wire ssc_sense_t i_sense,
  input wire logic o_ext_enabled,
  input wire logic o_soft_reset
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  chk_first_fcs: assert property ($rose(o_tx.valid) |-> o_tx.fcs)
    else $error("first byte is not a check byte");
  chk_tx_holds: assert property (o_tx.valid && !i_tx_ready && !i_rx.stop |=> $stable(o_tx))
    else $error("offered byte changed before it was taken");
  chk_abort_fcs: assert property (o_tx.valid && o_tx.abort |-> o_tx.fcs)
    else $error("abort flag on a data byte");
  chk_abort_ends: assert property (o_tx.valid && o_tx.abort && i_tx_ready |=> !o_tx.valid)
    else $error("data followed an abort");
  chk_stop_clears: assert property (i_rx.stop |=> !o_tx.valid)
    else $error("stop did not clear the offer");
  chk_ping_answer: assert property (i_rx.start ##1 (i_rx.valid && i_rx.data == i_dev_addr)
    ##1 (i_rx.valid && i_rx.data == 8'h00) [*2] |=> o_tx.valid && o_tx.fcs)
    else $error("ping not answered next cycle");
  chk_other_addr: assert property (i_rx.start ##1 (i_rx.valid && i_rx.data != i_dev_addr)
    |-> !o_tx.valid [*5])
    else $error("answer to a foreign address");
  chk_pulse_once: assert property (o_soft_reset |=> !o_soft_reset)
    else $error("reset pulse longer than one cycle");
  chk_reset_take: assert property ($rose(o_soft_reset) |-> $past(o_tx.valid && o_tx.fcs && i_tx_ready))
    else $error("reset pulse without a taken check byte");
endmodule // ssc_command_client_chk

bind ssc_command_client ssc_command_client_chk chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_rx(i_rx),
  .i_tx_ready(i_tx_ready), .o_tx(o_tx), .i_dev_addr(i_dev_addr), .i_dib(i_dib), .i_sense(i_sense),
  .o_ext_enabled(o_ext_enabled), .o_soft_reset(o_soft_reset));
`default_nettype wire

// ---- bench/ssc_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssc_host
  import ssc_pkg::*;
(
  // Clock and the client's answer.
  input wire logic i_clk,
  input wire ssc_tx_t i_tx,
  // Requests toward the client.
  output var ssc_rx_t o_rx,
  output var logic o_tx_ready
);
  logic [7:0] resp[$];
  logic [1:0] flg[$];

  // Link idle and not ready at time zero.
  initial begin
    o_rx = '0;
    o_tx_ready = 1'b0;
  end

  // Check value folded MSB first from zero.
  function automatic logic [7:0] crc(input logic [7:0] b[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (b[i]) begin
      c = c ^ b[i];
      for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // One frame: start, bytes back to back, collect the answer, then a bus stop unless held.
  task automatic frame(input logic [7:0] b[$], input bit slow, input bit hold = 1'b0);
    int idle;
    idle = 0;
    resp.delete();
    flg.delete();
    @(posedge i_clk) o_rx <= '{1'b1, 1'b0, 1'b0, ~o_rx.data};
    foreach (b[i]) @(posedge i_clk) o_rx <= '{1'b0, 1'b0, 1'b1, b[i]};
    @(posedge i_clk) o_rx <= '{1'b0, 1'b0, 1'b0, ~o_rx.data};
    o_tx_ready <= 1'b1;
    for (int n = 0; n < 60 && idle < 4; n++) begin
      @(posedge i_clk);
      if (i_tx.valid && o_tx_ready) begin
        resp.push_back(i_tx.data);
        flg.push_back({i_tx.fcs, i_tx.abort});
      end
      idle = i_tx.valid ? 0 : idle + 1;
      o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    end
    if (!hold) begin
      @(posedge i_clk) o_rx <= '{1'b0, 1'b1, 1'b0, ~o_rx.data};
    end
    @(posedge i_clk) o_rx <= '{1'b0, 1'b0, 1'b0, ~o_rx.data};
  endtask
endmodule // ssc_host
`default_nettype wire

// ---- design/ssc_command_client.sv ----
`include "ssc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module ssc_command_client
  import ssc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Byte link from and to the bit-level transport.
  input wire ssc_rx_t i_rx,
  input wire logic i_tx_ready,
  output var ssc_tx_t o_tx,
  // Device address and identifier block, byte 0 in bits 7..0.
  input wire logic [7:0] i_dev_addr,
  input wire logic [127:0] i_dib,
  // Measurement results.
  input wire ssc_sense_t i_sense,
  // Status toward the rest of the device.
  output var logic o_ext_enabled,
  output var logic o_soft_reset
);

  ssc_state_t state_reg;
  ssc_kind_t kind_reg;
  ssc_kind_t dec_kind;
  logic [7:0] wlen_reg;
  logic [7:0] rlen_reg;
  logic [7:0] cmd_reg;
  logic [7:0] wrem_reg;
  logic [7:0] idx_reg;
  logic [7:0] ptr_reg;
  logic [7:0] crc_reg;
  logic abort_reg;
  logic abort_idle_reg;
  logic reset_pend_reg;
  logic addr_seen_reg;
  logic [127:0] snap_reg;
  logic [127:0] dec_snap;
  logic dec_abort;
  logic dec_idle;
  logic dec_reset;
  logic [7:0] vreg_mem [0:`SSC_VREG_COUNT-1];
  logic [`SSC_VOLT_CHANNELS-1:0][15:0] volt_word;
  logic [15:0] ext_word;
  logic [7:0] crc_in;
  logic [7:0] crc_upd;
  logic rx_byte;
  logic tx_take;
  logic sensor_cmd;

  // A byte arrives, or the transport takes the byte on offer.
  assign rx_byte = i_rx.valid;
  assign tx_take = o_tx.valid && i_tx_ready;

  // Every supply reading is formatted by its own small formatter.
  generate
    for (genvar g = 0; g < `SSC_VOLT_CHANNELS; g++) begin : g_volt
      ssc_volt_format u_fmt (
        .i_raw  (i_sense.volt_raw[g]),
        .o_word (volt_word[g])
      );
    end
  endgenerate

  // Remote temperature with diode faults substituted.
  assign ext_word = i_sense.diode_open ? `SSC_EXT_OPEN_WORD :
                    i_sense.diode_short ? `SSC_EXT_SHORT_WORD : i_sense.ext_temp;

  // The check value folds in received bytes, or read data as it leaves.
  assign crc_in = (state_reg == ST_RDATA) ? o_tx.data : i_rx.data;

  ssc_crc8 u_crc (
    .i_crc  (crc_reg),
    .i_data (crc_in),
    .o_crc  (crc_upd)
  );

  // Sensor commands get full length checking, as does the identifier command.
  assign sensor_cmd = (i_rx.data == `SSC_CMD_TEMP) || (i_rx.data == `SSC_CMD_EXT_TEMP) ||
                      ((i_rx.data >= `SSC_CMD_VOLT_FIRST) && (i_rx.data <= `SSC_CMD_VOLT_LAST));

  // Decodes the command byte against the lengths already received.
  always_comb begin
    dec_kind = KIND_NONE;
    dec_snap = '0;
    dec_abort = 1'b0;
    dec_idle = 1'b0;
    dec_reset = 1'b0;
    if (sensor_cmd && (wlen_reg != `SSC_WLEN_ONE)) begin
      dec_abort = 1'b1;
      dec_idle = 1'b1;
    end else if (i_rx.data == `SSC_CMD_TEMP) begin
      dec_kind = KIND_SNAP;
      if (rlen_reg == `SSC_RLEN_ONE_WORD) begin
        dec_snap = {112'h0, i_sense.int_temp};
      end else if (rlen_reg == `SSC_RLEN_TWO_WORDS) begin
        dec_snap = {96'h0, ext_word, i_sense.int_temp};
      end else begin
        dec_abort = 1'b1;
      end
    end else if (i_rx.data == `SSC_CMD_EXT_TEMP) begin
      dec_kind = KIND_SNAP;
      if (rlen_reg == `SSC_RLEN_ONE_WORD) begin
        dec_snap = {112'h0, ext_word};
      end else begin
        dec_abort = 1'b1;
      end
    end else if (sensor_cmd) begin
      dec_kind = KIND_SNAP;
      if (rlen_reg == `SSC_RLEN_ONE_WORD) begin
        dec_snap = {112'h0, volt_word[i_rx.data[2:0]]};
      end else if ((rlen_reg == `SSC_RLEN_FIVE_WORDS) && (i_rx.data == `SSC_CMD_VOLT_FIRST)) begin
        dec_snap = {48'h0, volt_word};
      end else begin
        dec_abort = 1'b1;
      end
    end else if (i_rx.data == `SSC_CMD_DIB) begin
      dec_kind = KIND_SNAP;
      dec_snap = i_dib;
      if ((wlen_reg != `SSC_WLEN_ONE) ||
          ((rlen_reg != `SSC_RLEN_DIB_SHORT) && (rlen_reg != `SSC_RLEN_DIB_LONG))) begin
        dec_abort = 1'b1;
      end
    end else if ((i_rx.data == `SSC_CMD_REG_WRITE) || (i_rx.data == `SSC_CMD_REG_READ)) begin
      // Lengths pass unchecked; only the extension enable gates these.
      dec_kind = KIND_REG;
      dec_abort = !o_ext_enabled;
    end else if (i_rx.data == `SSC_CMD_RESET) begin
      dec_reset = 1'b1;
    end else if ((i_rx.data == `SSC_CMD_EXT_ENABLE) || (i_rx.data == `SSC_CMD_EXT_DISABLE)) begin
      dec_abort = 1'b0;
    end else begin
      dec_abort = 1'b1;
    end
  end

  // Picks read byte i from the snapshot or from the vendor registers.
  function automatic logic [7:0] resp_byte(input logic [7:0] i);
    logic [7:0] a;
    a = ptr_reg + i;
    if (kind_reg == KIND_REG) begin
      resp_byte = vreg_mem[a];
    end else if (i < 8'h10) begin
      resp_byte = snap_reg[{i[3:0], 3'b000} +: 8];
    end else begin
      resp_byte = 8'h00;
    end
  endfunction

  // Frame sequencer: header, command, write data, check byte, read data, check byte.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || o_soft_reset) begin
      state_reg <= ST_IDLE;
      kind_reg <= KIND_NONE;
      wlen_reg <= 8'h00;
      rlen_reg <= 8'h00;
      cmd_reg <= 8'h00;
      wrem_reg <= 8'h00;
      idx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      crc_reg <= `SSC_CRC_INIT;
      abort_reg <= 1'b0;
      abort_idle_reg <= 1'b0;
      reset_pend_reg <= 1'b0;
      addr_seen_reg <= 1'b0;
      snap_reg <= '0;
      o_tx <= '0;
    end else if (i_rx.stop) begin
      state_reg <= ST_IDLE;
      o_tx <= '0;
    end else if (i_rx.start && (state_reg != ST_WSTOP)) begin
      state_reg <= ST_ADDR;
      crc_reg <= `SSC_CRC_INIT;
      o_tx <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (rx_byte) begin
            crc_reg <= crc_upd;
            state_reg <= (i_rx.data == i_dev_addr) ? ST_WLEN : ST_WSTOP;
          end
        end
        ST_WLEN: begin
          if (rx_byte) begin
            wlen_reg <= i_rx.data;
            crc_reg <= crc_upd;
            state_reg <= ST_RLEN;
          end
        end
        ST_RLEN: begin
          if (rx_byte) begin
            rlen_reg <= i_rx.data;
            crc_reg <= crc_upd;
            reset_pend_reg <= 1'b0;
            kind_reg <= KIND_NONE;
            if (wlen_reg == 8'h00) begin
              // A ping carrying a read length is refused.
              abort_reg <= (i_rx.data != 8'h00);
              abort_idle_reg <= 1'b0;
              o_tx <= '{valid: 1'b1, fcs: 1'b1, abort: (i_rx.data != 8'h00),
                        data: (i_rx.data != 8'h00) ? ~crc_upd : crc_upd};
              state_reg <= ST_FCS1;
            end else begin
              state_reg <= ST_CMD;
            end
          end
        end
        ST_CMD: begin
          if (rx_byte) begin
            cmd_reg <= i_rx.data;
            crc_reg <= crc_upd;
            kind_reg <= dec_kind;
            snap_reg <= dec_snap; // Atomic: every byte of a sensor or identifier reply comes from one capture.
            abort_reg <= dec_abort;
            abort_idle_reg <= dec_idle;
            reset_pend_reg <= dec_reset;
            addr_seen_reg <= 1'b0;
            wrem_reg <= wlen_reg - 8'h01;
            if (wlen_reg == `SSC_WLEN_ONE) begin
              o_tx <= '{valid: 1'b1, fcs: 1'b1, abort: dec_abort,
                        data: dec_abort ? ~crc_upd : crc_upd};
              state_reg <= ST_FCS1;
            end else begin
              state_reg <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (rx_byte) begin
            crc_reg <= crc_upd;
            wrem_reg <= wrem_reg - 8'h01;
            // First byte is the start register, later bytes advance the pointer.
            if (!addr_seen_reg) begin
              ptr_reg <= i_rx.data;
              addr_seen_reg <= 1'b1;
            end else begin
              ptr_reg <= ptr_reg + 8'h01;
            end
            if (wrem_reg == 8'h01) begin
              o_tx <= '{valid: 1'b1, fcs: 1'b1, abort: abort_reg,
                        data: abort_reg ? ~crc_upd : crc_upd};
              state_reg <= ST_FCS1;
            end
          end
        end
        ST_FCS1: begin
          if (tx_take) begin
            crc_reg <= `SSC_CRC_INIT;
            idx_reg <= 8'h00;
            if (abort_reg) begin
              o_tx <= '0;
              state_reg <= abort_idle_reg ? ST_IDLE : ST_WSTOP;
            end else if ((rlen_reg == 8'h00) || (kind_reg == KIND_NONE)) begin
              o_tx <= '0;
              state_reg <= ST_IDLE;
            end else begin
              o_tx <= '{valid: 1'b1, fcs: 1'b0, abort: 1'b0, data: resp_byte(8'h00)};
              state_reg <= ST_RDATA;
            end
          end
        end
        ST_RDATA: begin
          if (tx_take) begin
            crc_reg <= crc_upd;
            if (idx_reg == (rlen_reg - 8'h01)) begin
              o_tx <= '{valid: 1'b1, fcs: 1'b1, abort: 1'b0, data: crc_upd};
              state_reg <= ST_FCS2;
            end else begin
              idx_reg <= idx_reg + 8'h01;
              o_tx <= '{valid: 1'b1, fcs: 1'b0, abort: 1'b0,
                        data: resp_byte(idx_reg + 8'h01)};
            end
          end
        end
        ST_FCS2: begin
          if (tx_take) begin
            crc_reg <= `SSC_CRC_INIT;
            o_tx <= '0;
            state_reg <= ST_IDLE;
          end
        end
        ST_WSTOP: begin
        end
        default: begin
          state_reg <= ST_IDLE;
          o_tx <= '0;
        end
      endcase
    end
  end

  // Device reset pulse once the reset command's check byte has gone out.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= (state_reg == ST_FCS1) && tx_take && reset_pend_reg && !abort_reg;
    end
  end

  // Vendor extension enable, cleared by either reset.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || o_soft_reset) begin
      o_ext_enabled <= 1'b0;
    end else if ((state_reg == ST_CMD) && rx_byte && !i_rx.stop && !i_rx.start) begin
      if (i_rx.data == `SSC_CMD_EXT_ENABLE) begin
        o_ext_enabled <= 1'b1;
      end else if (i_rx.data == `SSC_CMD_EXT_DISABLE) begin
        o_ext_enabled <= 1'b0;
      end
    end
  end

  // Vendor registers: cleared by either reset, written byte by byte.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || o_soft_reset) begin
      for (int r = 0; r < `SSC_VREG_COUNT; r++) begin
        vreg_mem[r] <= `SSC_VREG_RESET;
      end
    end else if ((state_reg == ST_WDATA) && rx_byte && !i_rx.stop && !i_rx.start &&
                 addr_seen_reg && (cmd_reg == `SSC_CMD_REG_WRITE) && !abort_reg) begin
      vreg_mem[ptr_reg] <= i_rx.data;
    end
  end

endmodule // ssc_command_client

`default_nettype wire

// ---- design/ssc_consts.svh ----
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// Command codes decoded from the first write byte.
`define SSC_CMD_TEMP          8'h00
`define SSC_CMD_EXT_TEMP      8'h01
`define SSC_CMD_VOLT_FIRST    8'h10
`define SSC_CMD_VOLT_LAST     8'h14
`define SSC_CMD_REG_WRITE     8'hE0
`define SSC_CMD_REG_READ      8'hE1
`define SSC_CMD_EXT_ENABLE    8'hE2
`define SSC_CMD_EXT_DISABLE   8'hE3
`define SSC_CMD_RESET         8'hF6
`define SSC_CMD_DIB           8'hF7

// Write and read lengths that the sensor and identifier commands accept.
`define SSC_WLEN_ONE          8'h01
`define SSC_RLEN_ONE_WORD     8'h02
`define SSC_RLEN_TWO_WORDS    8'h04
`define SSC_RLEN_FIVE_WORDS   8'h0A
`define SSC_RLEN_DIB_SHORT    8'h08
`define SSC_RLEN_DIB_LONG     8'h10

// Remote diode fault words returned in place of the remote temperature.
`define SSC_EXT_OPEN_WORD     16'h8102
`define SSC_EXT_SHORT_WORD    16'h8103

// Frame check polynomial x^8+x^2+x+1 and its start value.
`define SSC_CRC_POLY          8'h07
`define SSC_CRC_INIT          8'h00

// Voltage word layout: sign bit, magnitude field, always-zero low bits.
`define SSC_VOLT_RAW_W        12
`define SSC_VOLT_ZERO_BITS    3
`define SSC_VOLT_CHANNELS     5

// Vendor register space and reset value of its cells.
`define SSC_VREG_COUNT        256
`define SSC_VREG_RESET        8'h00

`endif

// ---- design/ssc_crc8.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "ssc_consts.svh"

module ssc_crc8 (
  // Running check value and the byte to fold in.
  input wire logic [7:0] i_crc,
  input wire logic [7:0] i_data,
  // Updated check value.
  output logic [7:0] o_crc
);

  // Folds one byte in, most significant bit first.
  always_comb begin
    logic [7:0] c;
    c = i_crc ^ i_data;
    for (int b = 0; b < 8; b++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `SSC_CRC_POLY) : {c[6:0], 1'b0};
    end
    o_crc = c;
  end

endmodule // ssc_crc8

`default_nettype wire

// ---- design/ssc_pkg.sv ----
`include "ssc_consts.svh"

package ssc_pkg;

  // Byte stream from the transport layer: frame start, bus stop, one byte.
  typedef struct packed {
    logic start;
    logic stop;
    logic valid;
    logic [7:0] data;
  } ssc_rx_t;

  // Byte stream toward the transport layer.
  typedef struct packed {
    logic valid;
    logic fcs;
    logic abort;
    logic [7:0] data;
  } ssc_tx_t;

  // Latest conversion results from the measurement core.
  typedef struct packed {
    logic [15:0] int_temp;
    logic [15:0] ext_temp;
    logic diode_open;
    logic diode_short;
    logic [`SSC_VOLT_CHANNELS-1:0][`SSC_VOLT_RAW_W-1:0] volt_raw;
  } ssc_sense_t;

  // Frame sequencer states, one-hot.
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_ADDR  = 10'h002,
    ST_WLEN  = 10'h004,
    ST_RLEN  = 10'h008,
    ST_CMD   = 10'h010,
    ST_WDATA = 10'h020,
    ST_FCS1  = 10'h040,
    ST_RDATA = 10'h080,
    ST_FCS2  = 10'h100,
    ST_WSTOP = 10'h200
  } ssc_state_t;

  // Where read data comes from.
  typedef enum logic [1:0] {
    KIND_NONE = 2'h0,
    KIND_SNAP = 2'h1,
    KIND_REG  = 2'h2
  } ssc_kind_t;

endpackage

// ---- design/ssc_volt_format.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "ssc_consts.svh"

module ssc_volt_format (
  // Unsigned magnitude from the converter, 1/128 V per count.
  input wire logic [`SSC_VOLT_RAW_W-1:0] i_raw,
  // Reported word, 1/1024 V per count.
  output logic [15:0] o_word
);

  // Sign forced to zero and the three low bits cleared.
  assign o_word = {1'b0, i_raw, {`SSC_VOLT_ZERO_BITS{1'b0}}};

endmodule // ssc_volt_format

`default_nettype wire
